// *** hdl/uvp_host.sv ***
// Host controller that reads, programs, verifies and identifies the memory part.
// Assumes an external level shifter turns SUPPLY_HI and TRIGGER_HI into raised voltages.
`timescale 1ns/1ps
module uvp_host #(
  parameter int STD_CYC   = uvp_pkg::STD_CYC_DEF,
  parameter int INIT_CYC  = uvp_pkg::INIT_CYC_DEF,
  parameter int OVER_UNIT = uvp_pkg::OVER_UNIT_DEF
) (
  input  wire logic                          SYS_CLK,
  input  wire logic                          RST,
  input  wire logic                          REQ_VALID,
  output logic                               REQ_READY,
  input  wire uvp_pkg::uvp_req_s             REQ,
  output logic                               RSP_VALID,
  output uvp_pkg::uvp_rsp_s                  RSP,
  output logic [uvp_pkg::ADDR_W-1:0]         ADDR,
  output uvp_pkg::uvp_ctl_s                  CTL,
  input  wire logic [uvp_pkg::DATA_W-1:0]    DATA_I,
  output logic [uvp_pkg::DATA_W-1:0]         DATA_O,
  output logic                               DATA_OE_N
);
  import uvp_pkg::*;

  typedef enum logic [3:0] {
    IDLE, SETUP, PULSE, GAP, SAMPLE, OVER, DONE
  } uvp_state_e;

  uvp_state_e        state;
  uvp_state_e        next_state;
  uvp_req_s          cur;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic [3:0]        tries;
  logic [DATA_W-1:0] rd_sync;
  logic              fail;
  logic              setup_mode;
  // Set once a fast byte verifies, so the overprogram pulse gets its own setup first.
  logic              over_pend;

  // ==========================================================================
  // Returns true when a byte carries odd parity across all eight bits.
  function automatic logic odd_parity(input logic [DATA_W-1:0] b);
    return ^b;
  endfunction : odd_parity

  // Cycles of the overprogram pulse for a given initial pulse count.
  function automatic logic [CNT_W-1:0] over_cycles(input logic [3:0] n);
    return CNT_W'(OVER_UNIT * int'(n));
  endfunction : over_cycles

  uvp_sync #(.W(DATA_W)) u_sync (
    .SYS_CLK (SYS_CLK),
    .RST     (RST),
    .D       (DATA_I),
    .Q       (rd_sync)
  );

  // ==========================================================================
  // Decoding of the current command.
  wire is_prog   = (cur.cmd == UVP_CMD_PROG_STD) || (cur.cmd == UVP_CMD_PROG_FAST);
  wire is_fast   = (cur.cmd == UVP_CMD_PROG_FAST);
  wire is_ident  = (cur.cmd == UVP_CMD_IDENT);
  wire needs_vpp = is_prog || (cur.cmd == UVP_CMD_VERIFY);
  // Programming can only clear bits, so a one over a stored zero never verifies.
  wire match     = (rd_sync == cur.data); // [R5]
  wire cnt_zero  = (cnt == '0);
  // The counter runs down to zero inclusive, so one is taken off to hit the width exactly.
  wire [CNT_W-1:0] pulse_len = is_fast ? CNT_W'(INIT_CYC - 1) : CNT_W'(STD_CYC - 1); // [R7] [R14]
  wire [CNT_W-1:0] read_len  = CNT_W'(ACC_CYC + 4);

  // ==========================================================================
  // Sequencer: one request at a time, in whatever address order it arrives.
  always_comb begin
    next_state = state;
    next_cnt   = cnt_zero ? cnt : cnt - 1'b1;
    unique case (state)
      IDLE: begin
        if (REQ_VALID) begin // [R8]
          next_state = SETUP;
          next_cnt   = CNT_W'(SETUP_CYC);
        end
      end
      SETUP: begin
        if (cnt_zero && over_pend) begin
          next_state = OVER; // [R12] [R13]
          next_cnt   = over_cycles(tries) - 1'b1;
        end else if (cnt_zero) begin
          next_state = is_prog ? PULSE : SAMPLE;
          next_cnt   = is_prog ? pulse_len : read_len;
        end
      end
      PULSE: begin
        if (cnt_zero) begin
          next_state = GAP;
          next_cnt   = CNT_W'(SETUP_CYC);
        end
      end
      GAP: begin
        if (cnt_zero) begin
          next_state = (is_fast || !is_prog) ? SAMPLE : DONE;
          next_cnt   = read_len;
        end
      end
      SAMPLE: begin
        if (cnt_zero) begin
          if (!is_fast) begin
            next_state = DONE;
          end else if (match) begin
            next_state = SETUP; // [R12]
            next_cnt   = CNT_W'(SETUP_CYC);
          end else if (tries == 4'(MAX_INIT_PULSES)) begin
            next_state = DONE; // [R11]
          end else begin
            next_state = SETUP;
            next_cnt   = CNT_W'(SETUP_CYC);
          end
        end
      end
      OVER: begin
        if (cnt_zero) begin
          next_state = DONE;
        end
      end
      DONE: next_state = IDLE;
      default: next_state = IDLE;
    endcase
  end

  assign setup_mode = (state == SETUP) || (state == GAP);

  // ==========================================================================
  // State, counter and the captured request.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state <= IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cur       <= '0;
      tries     <= '0;
      fail      <= 1'b0;
      over_pend <= 1'b0;
    end else if (state == IDLE && REQ_VALID) begin
      cur       <= REQ;
      tries     <= '0;
      fail      <= 1'b0;
      over_pend <= 1'b0;
    end else if (state == SETUP && cnt_zero && is_prog && !over_pend) begin
      tries <= tries + 4'h1; // [R11] [R12]
    end else if (state == SAMPLE && cnt_zero && is_fast) begin
      fail      <= !match && (tries == 4'(MAX_INIT_PULSES));
      over_pend <= match;
    end
  end

  // ==========================================================================
  // Pin drive. Select stays low for the whole job; strobe low only in PULSE or OVER.
  // The host drives data only while the gate is high, which avoids bus contention.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      CTL       <= '{select_n: 1'b1, gate_n: 1'b1, strobe_n: 1'b1,
                     supply_hi: 1'b0, trigger_hi: 1'b0}; // [R3]
      ADDR      <= '0;
      DATA_O    <= ERASED_BYTE;
      DATA_OE_N <= 1'b1;
    end else begin
      CTL.select_n   <= (state == IDLE) || (state == DONE); // [R4] [R9]
      CTL.strobe_n   <= !((state == PULSE) || (state == OVER)); // [R6] [R9] [R13]
      CTL.gate_n     <= !(state == SAMPLE); // [R1] [R2] [R10] [R20]
      CTL.supply_hi  <= needs_vpp && (state != IDLE); // [R6] [R10]
      CTL.trigger_hi <= is_ident && (state != IDLE); // [R16]
      // Identifier mode keeps every other address line low.
      ADDR           <= is_ident ? {{(ADDR_W-1){1'b0}}, cur.addr[0]} : cur.addr; // [R17] [R18]
      DATA_O         <= cur.data;
      DATA_OE_N      <= !(is_prog && (setup_mode || state == PULSE || state == OVER)); // [R6]
    end
  end

  // ==========================================================================
  // Handshake and answer.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      REQ_READY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP       <= '0;
    end else begin
      REQ_READY <= (next_state == IDLE) && !(state == IDLE && REQ_VALID);
      RSP_VALID <= (state == DONE);
      if (state == SAMPLE && cnt_zero) begin
        RSP.data      <= rd_sync; // [R15]
        RSP.parity_ok <= odd_parity(rd_sync); // [R19]
      end
      RSP.fail   <= fail;
      RSP.pulses <= tries;
    end
  end

endmodule : uvp_host

// *** hdl/uvp_pkg.sv ***
// Package for the host-side controller of a 16K x 8 UV-erasable memory.
// Assumes a single 100 MHz system clock and an outside pin driver for the part.
//
// Overview of operation
// [R1] Part drives data only when selected and gated.
// [R2] Data valid after gate delay once selected.
// [R3] Deselect means standby, outputs float.
// [R4] Select per device; gate tied to read strobe.
// [R5] Erased bits are one; program only clears.
// [R6] Program: raised supply, select and strobe low.
// [R7] Standard program: one 50 ms strobe per location.
// [R8] Locations may be written in any order.
// [R9] High select or strobe inhibits programming.
// [R10] Verify: select, gate low, strobe high, supply raised.
// [R11] Fast: 1 ms pulses, verify each, at most fifteen.
// [R12] Overprogram pulse lasts four ms times count.
// [R13] Overprogram stays within 3.8 to 63 ms.
// [R14] Initial pulse within five percent of 1 ms.
// [R15] Afterwards re-read every byte at nominal supply.
// [R16] High voltage on trigger line gives identifier mode.
// [R17] Other address lines low during identifier mode.
// [R18] Byte select low maker code, high type code.
// [R19] Identifier bytes carry odd parity in bit seven.
// [R20] Selected but ungated means outputs float.
package uvp_pkg;

  // ==========================================================================
  // Sizes and timing.
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_ACC_NS = 450;
  localparam int T_SETUP_US = 2;
  localparam int T_STD_PULSE_MS = 50;
  localparam int T_INIT_PULSE_MS = 1;
  localparam int T_OVER_UNIT_MS = 4;
  localparam int MAX_INIT_PULSES = 15;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (T_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STD_CYC_DEF = T_STD_PULSE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int INIT_CYC_DEF = T_INIT_PULSE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int OVER_UNIT_DEF = T_OVER_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W = 24;
  localparam int PAR_BIT = 7;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;

  // ==========================================================================
  // Commands of the user port.
  typedef enum logic [2:0] {
    UVP_CMD_READ,
    UVP_CMD_PROG_STD,
    UVP_CMD_PROG_FAST,
    UVP_CMD_VERIFY,
    UVP_CMD_IDENT
  } uvp_cmd_e;

  typedef struct packed {
    uvp_cmd_e              cmd;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     data;
  } uvp_req_s;

  typedef struct packed {
    logic [DATA_W-1:0]     data;
    logic                  fail;
    logic                  parity_ok;
    logic [3:0]            pulses;
  } uvp_rsp_s;

  // Control pins of the part, all active low except the supply and trigger.
  typedef struct packed {
    logic                  select_n;
    logic                  gate_n;
    logic                  strobe_n;
    logic                  supply_hi;
    logic                  trigger_hi;
  } uvp_ctl_s;

endpackage : uvp_pkg

// *** hdl/uvp_sync.sv ***
// Three-stage synchroniser for the data bus coming back from the part.
// Assumes the bus is only read after it has been stable for several cycles.
`timescale 1ns/1ps
module uvp_sync #(
  parameter int W = 8
) (
  input  wire logic         SYS_CLK,
  input  wire logic         RST,
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ==========================================================================
  // Only s2 reads s1; a new value counts once s2 and s3 agree.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      Q  <= '0;
    end else begin
      s1 <= D;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        Q <= s3;
      end
    end
  end

endmodule : uvp_sync

// *** tb/tb_uvp_host.sv ***
// Self-checking bench: reads, identifies, programs and verifies through a part model.
// Assumes short pulse parameters so the run stays near sixteen and a half thousand cycles.
`timescale 1ns/1ps
module tb_uvp_host;
  import uvp_pkg::*;
  logic SYS_CLK = 1'b0, RST = 1'b1, REQ_VALID = 1'b0, REQ_READY, RSP_VALID, DATA_OE_N;
  uvp_req_s   REQ = '0;
  uvp_rsp_s   RSP;
  uvp_ctl_s   CTL;
  logic [13:0] ADDR, a [6];
  logic [7:0] DATA_O, dev_q, d [6];
  logic [15:0] exp_q [$], e, rnd = 16'h1F77;
  logic [13:0] m;
  int         bad_count = 0, tests_run = 0, cyc = 0;
  wire  [7:0] bus = (DATA_OE_N === 1'b0) ? DATA_O : dev_q;
  always #5 SYS_CLK = ~SYS_CLK;
  uvp_host #(.STD_CYC(50), .INIT_CYC(10), .OVER_UNIT(40)) i_uvp_host (.SYS_CLK(SYS_CLK),
    .RST(RST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ(REQ), .RSP_VALID(RSP_VALID),
    .RSP(RSP), .ADDR(ADDR), .CTL(CTL), .DATA_I(bus), .DATA_O(DATA_O), .DATA_OE_N(DATA_OE_N));
  uvp_dev i_uvp_dev (.addr(ADDR), .ctl(CTL), .dq_in(bus), .dq_out(dev_q));
  function automatic logic [15:0] xs(logic [15:0] x);
    x = x ^ (x << 7);
    x = x ^ (x >> 9);
    return x ^ (x << 8);
  endfunction : xs
  function automatic logic [15:0] ex(logic [1:0] k, logic [7:0] v, logic f, logic [3:0] p);
    return {k, v, f, 1'b1, p};
  endfunction : ex
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // One job at a time: the note goes on the queue as the request is raised.
  task automatic job(uvp_cmd_e c, logic [13:0] ad, logic [7:0] dt, logic [15:0] x);
    while (exp_q.size() != 0 || REQ_READY !== 1'b1) @(negedge SYS_CLK);
    REQ = '{c, ad, dt};
    REQ_VALID = 1'b1;
    exp_q.push_back(x);
    @(negedge SYS_CLK);
    REQ_VALID = 1'b0;
  endtask : job
  // Kind selects the fields compared: data, data with parity, fail with count, fail.
  always @(negedge SYS_CLK) if (RSP_VALID === 1'b1) begin
    e = exp_q.pop_front();
    m = (e[15:14] == 2'h0) ? 14'h3FC0 : (e[15:14] == 2'h1) ? 14'h3FD0 :
        (e[15:14] == 2'h2) ? 14'h002F : 14'h0020;
    tests_run++;
    if ((RSP & m) !== (e[13:0] & m)) begin
      $display("mismatch at %0t: got %h expected %h", $time, RSP & m, e[13:0] & m);
      bad_count++;
    end
  end
  // A hang counts as a mismatch and ends the run.
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    repeat (5) @(negedge SYS_CLK);
    RST = 1'b0;
    repeat (2) @(negedge SYS_CLK);
    job(UVP_CMD_READ, 14'h0005, 8'h00, ex(2'h0, ERASED_BYTE, 1'b0, 4'h0));
    job(UVP_CMD_IDENT, 14'h0000, 8'h00, ex(2'h1, 8'h8A, 1'b0, 4'h0));
    job(UVP_CMD_IDENT, 14'h0001, 8'h00, ex(2'h1, 8'h8C, 1'b0, 4'h0));
    for (int i = 0; i < 6; i++) begin
      rnd = xs(rnd);
      a[i] = {i[3:0], rnd[9:0]};
      d[i] = rnd[15:8] & 8'h7F;
      job(UVP_CMD_PROG_FAST, a[i], d[i], ex(2'h2, 8'h00, 1'b0, {2'h0, a[i][1:0]} + 4'h1));
    end
    for (int i = 5; i >= 0; i--) job(UVP_CMD_READ, a[i], 8'h00, ex(2'h0, d[i], 1'b0, 4'h0));
    job(UVP_CMD_PROG_STD, 14'h2000, 8'h5A, ex(2'h3, 8'h00, 1'b0, 4'h0));
    job(UVP_CMD_VERIFY, 14'h2000, 8'h00, ex(2'h0, 8'h5A, 1'b0, 4'h0));
    job(UVP_CMD_PROG_FAST, 14'h2000, 8'hFF, ex(2'h2, 8'h00, 1'b1, 4'hF));
    job(UVP_CMD_READ, 14'h2000, 8'h00, ex(2'h0, 8'h5A, 1'b0, 4'h0));
    while (exp_q.size() != 0) @(negedge SYS_CLK);
    summarize();
  end
endmodule : tb_uvp_host

// *** tb/uvp_dev.sv ***
// Pin-level model of the memory part; a byte takes after low address bits plus one pulses.
// Assumes the bench resolves the shared data wire and returns it on dq_in.
`timescale 1ns/1ps
module uvp_dev #(
  parameter logic [7:0] MAKER = 8'h8A, // Arbitrary value, odd parity.
  parameter logic [7:0] KIND  = 8'h8C  // Arbitrary value, odd parity.
) (
  input  wire logic [uvp_pkg::ADDR_W-1:0] addr,
  input  wire uvp_pkg::uvp_ctl_s          ctl,
  input  wire logic [uvp_pkg::DATA_W-1:0] dq_in,
  output wire logic [uvp_pkg::DATA_W-1:0] dq_out
);
  import uvp_pkg::*;
  logic [7:0] mem [2**ADDR_W];
  logic [7:0] hits [2**ADDR_W];
  logic [7:0] flt = 8'h00;
  wire        drv = !ctl.select_n && !ctl.gate_n && ctl.strobe_n;
  wire  [7:0] val = ctl.trigger_hi ? (addr[0] ? KIND : MAKER) : mem[addr];
  // Released lines show the inverse of the last byte, so stale data never passes.
  assign #100 dq_out = drv ? val : flt;
  always @(negedge drv) flt = ~val;
  // Erased part; a pulse may only clear bits, at any address in any order.
  initial foreach (mem[i]) begin
    mem[i] = ERASED_BYTE;
    hits[i] = 8'h00;
  end
  always @(posedge ctl.strobe_n) if (!ctl.select_n && ctl.supply_hi) begin
    hits[addr] = hits[addr] + 8'h01;
    if (hits[addr] > {6'h00, addr[1:0]}) mem[addr] = mem[addr] & dq_in;
  end
endmodule : uvp_dev

// *** tb/uvp_host_chk.sv ***
// Checker for the host controller: timing and levels on the pins of the part.
// Assumes it is bound to uvp_host and sees only that module's ports.
`timescale 1ns/1ps
module uvp_host_chk #(
  parameter int STD_CYC   = 50,
  parameter int INIT_CYC  = 10,
  parameter int OVER_UNIT = 40
) (
  input wire logic                      SYS_CLK,
  input wire logic                      RST,
  input wire logic                      RSP_VALID,
  input wire uvp_pkg::uvp_rsp_s         RSP,
  input wire logic [uvp_pkg::ADDR_W-1:0] ADDR,
  input wire uvp_pkg::uvp_ctl_s         CTL,
  input wire logic [uvp_pkg::DATA_W-1:0] DATA_O,
  input wire logic                      DATA_OE_N
);
  import uvp_pkg::*;
  // ==========================================================================
  // Pulse measurement.
  logic [31:0] len;
  logic [4:0]  npul;
  logic        st_q;
  wire         st_rise = CTL.strobe_n && !st_q;
  // Low cycles of the strobe, and initial pulses since the part was selected.
  always_ff @(posedge SYS_CLK) begin
    st_q <= RST | CTL.strobe_n;
    len  <= CTL.strobe_n ? 32'h0 : len + 32'h1;
    if (RST || CTL.select_n) npul <= 5'h00;
    else if (st_rise && len == INIT_CYC) npul <= npul + 5'h01;
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // ==========================================================================
  // Assertions.
  property p_no_clash; !DATA_OE_N |-> CTL.gate_n; endproperty
  a_no_clash: assert property (p_no_clash) else $error("host drives gated bus");
  property p_prog; !CTL.strobe_n |-> !CTL.select_n && CTL.supply_hi && !DATA_OE_N; endproperty
  a_prog: assert property (p_prog) else $error("strobe outside program mode");
  property p_verify; !CTL.gate_n && CTL.supply_hi |-> CTL.strobe_n; endproperty
  a_verify: assert property (p_verify) else $error("gate and strobe both low");
  property p_id; CTL.trigger_hi |-> ADDR[13:1] == 13'h0 && !CTL.supply_hi; endproperty
  a_id: assert property (p_id) else $error("address lines set in identifier mode");
  property p_hold; !CTL.strobe_n && !$past(CTL.strobe_n) |-> $stable(ADDR) && $stable(DATA_O);
  endproperty
  a_hold: assert property (p_hold) else $error("address or data moved in pulse");
  property p_setup; $fell(CTL.strobe_n) |-> $past(!DATA_OE_N && !CTL.select_n, 8); endproperty
  a_setup: assert property (p_setup) else $error("pulse without setup");
  property p_std; st_rise && npul == 5'h00 |-> len == STD_CYC || len == INIT_CYC; endproperty
  a_std: assert property (p_std) else $error("bad pulse width");
  // OVER_UNIT already holds the four-unit step, so the width is count times unit.
  property p_over; st_rise && len != INIT_CYC && npul != 5'h00 |-> len == npul * OVER_UNIT;
  endproperty
  a_over: assert property (p_over) else $error("bad overprogram width");
  property p_max; st_rise && len == INIT_CYC |-> npul < 5'h0F; endproperty
  a_max: assert property (p_max) else $error("too many initial pulses");
  property p_fail; RSP_VALID && RSP.fail |-> RSP.pulses == 4'hF; endproperty
  a_fail: assert property (p_fail) else $error("failure before fifteen pulses");
  c_over: cover property (st_rise && npul != 5'h00 && len != INIT_CYC);
  c_id: cover property (CTL.trigger_hi && !CTL.gate_n);
  c_fail: cover property (RSP_VALID && RSP.fail);
endmodule : uvp_host_chk

bind uvp_host uvp_host_chk #(.STD_CYC(STD_CYC), .INIT_CYC(INIT_CYC), .OVER_UNIT(OVER_UNIT))
  i_chk (.SYS_CLK(SYS_CLK), .RST(RST), .RSP_VALID(RSP_VALID), .RSP(RSP), .ADDR(ADDR),
  .CTL(CTL), .DATA_O(DATA_O), .DATA_OE_N(DATA_OE_N));
